// ===== rtl/ssp_core.sv
// serial spi port core: avalon register slave, master and slave shift engine
// Notes on behaviour
// R01: in 4-pin master mode the slave enable pin is an enable output when the mode select is 1, else an input.
// R02: with the pin as input, a master transfer aborts when it goes inactive and restarts only once it is active.
// R03: the serial clock idles low for polarity 0 and high for polarity 1.
// R04: a master feeding a phase-1 slave holds the clock idle before the slave leaves soft reset.
// R05: the tx flag sets when the holding buffer empties, the rx flag when a full character is received.
// R06: busy and the clock request are high only while a transfer runs and drop when it ends.
// R07: setting then clearing soft reset returns flags, buffers and shift logic to their initial state; rxbuf_r and txbuf_r keep their data.
// R08: in conflict mode software loads data only while the pin is active and reloads after an abort.
// R09: a phase-1 slave presents the first bit of every character correctly, with the clock asynchronous.
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ssp_core (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // avalon-mm slave
   input wire logic [ssp_pkg::AW-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [ssp_pkg::DW-1:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [ssp_pkg::DW-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // serial clock pin
   input wire logic i_sclk,
   output logic o_sclk,
   output logic o_sclk_oe,
   // master out slave in pin
   input wire logic i_simo,
   output logic o_simo,
   output logic o_simo_oe,
   // slave out master in pin
   input wire logic i_somi,
   output logic o_somi,
   output logic o_somi_oe,
   // slave_enable_pin, active low
   input wire logic i_slave_enable_pin,
   output logic o_slave_enable_pin,
   output logic o_slave_enable_pin_oe,
   // interrupt, busy and module clock request
   output logic o_irq,
   output logic o_transfer_active_flag,
   output logic o_clk_req
);
   import ssp_pkg::*;

   logic [NPIN-1:0] pin_s;
   logic [NPIN-1:0] pin_raw;

   assign pin_raw = {i_slave_enable_pin, i_somi, i_simo, i_sclk};

   ssp_sync #(.W(NPIN)) u_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_d(pin_raw),
      .o_q(pin_s)
   );

   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // bus group
   logic wait_r, wait_nxt;
   logic [DW-1:0] rdata_r, rdata_nxt;
   ssp_ctrl_t ctrl_r, ctrl_nxt;
   logic [7:0] div_r, div_nxt;
   logic [NFLAG-1:0] mask_r, mask_nxt;
   logic wr, wr_txb;
   logic [NFLAG-1:0] w1c;

   // engine group
   ssp_state_t state_r, state_nxt;
   logic [3:0] hcnt_r, hcnt_nxt;
   logic [7:0] divcnt_r, divcnt_nxt;
   logic [7:0] sr_r, sr_nxt;
   logic [7:0] rsr_r, rsr_nxt;
   logic [7:0] rxbuf_r, rxbuf_nxt;
   logic [7:0] txbuf_r, txbuf_nxt;
   logic txfull_r, txfull_nxt;
   logic sclk_r, sclk_nxt;
   logic dout_r, dout_nxt;
   logic sclk_d_r, sclk_d_nxt;
   logic armed_r, armed_nxt;
   logic [NFLAG-1:0] flag_r, flag_nxt;
   logic busy_r, busy_nxt;
   logic irq_r, irq_nxt;
   logic sclk_oe_r, sclk_oe_nxt;
   logic simo_oe_r, simo_oe_nxt;
   logic somi_oe_r, somi_oe_nxt;
   logic ste_oe_r, ste_oe_nxt;
   logic ste_o_r, ste_o_nxt;

   always_comb begin
      wait_nxt = 1'b1;
      rdata_nxt = rdata_r;
      ctrl_nxt = ctrl_r;
      div_nxt = div_r;
      mask_nxt = mask_r;
      // one wait cycle; read data is latched at the edge that ends it, a write is taken at the edge that sees waitrequest low
      if ((i_avs_read || i_avs_write) && wait_r) begin
         wait_nxt = 1'b0;
         if (i_avs_read) begin
            case (i_avs_address)
               OFS_CTRL: rdata_nxt = DW'(ctrl_r);
               OFS_DIV: rdata_nxt = DW'(div_r);
               OFS_STAT: rdata_nxt = DW'({txfull_r, busy_r});
               OFS_FLAG: rdata_nxt = DW'(flag_r);
               OFS_MASK: rdata_nxt = DW'(mask_r);
               OFS_TXB: rdata_nxt = DW'(txbuf_r);
               OFS_RXB: rdata_nxt = DW'(rxbuf_r);
               default: rdata_nxt = '0;
            endcase
         end
      end
      wr = i_avs_write && !wait_r && i_avs_byteenable[0];
      wr_txb = wr && hit(i_avs_address, OFS_TXB);
      w1c = (wr && hit(i_avs_address, OFS_FLAG)) ? i_avs_writedata[NFLAG-1:0] : '0;
      if (wr && hit(i_avs_address, OFS_CTRL)) begin
         ctrl_nxt = ssp_ctrl_t'(i_avs_writedata[$bits(ssp_ctrl_t)-1:0]);
      end
      if (wr && hit(i_avs_address, OFS_DIV)) begin
         div_nxt = i_avs_writedata[7:0];
      end
      if (wr && hit(i_avs_address, OFS_MASK)) begin
         mask_nxt = i_avs_writedata[NFLAG-1:0];
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wait_r <= 1'b1;
         rdata_r <= '0;
         ctrl_r <= CTRL_RST;
         div_r <= DIV_RST;
         mask_r <= MASK_RST;
      end else begin
         wait_r <= wait_nxt;
         rdata_r <= rdata_nxt;
         ctrl_r <= ctrl_nxt;
         div_r <= div_nxt;
         mask_r <= mask_nxt;
      end
   end

   logic ste_act, ste_ok, act, prev_act, rx_in, edge_v, lead_v, load_v;
   logic [7:0] byte_v, rx_byte;
   logic [NFLAG-1:0] flag_set;

   always_comb begin
      state_nxt = state_r;
      hcnt_nxt = hcnt_r;
      divcnt_nxt = divcnt_r;
      sr_nxt = sr_r;
      rsr_nxt = rsr_r;
      rxbuf_nxt = rxbuf_r;
      txbuf_nxt = txbuf_r;
      txfull_nxt = txfull_r;
      sclk_nxt = sclk_r;
      dout_nxt = dout_r;
      armed_nxt = armed_r;
      flag_set = '0;
      edge_v = 1'b0;
      lead_v = 1'b0;
      load_v = 1'b0;
      byte_v = BYTE_ZERO;
      rx_byte = rsr_r;
      sclk_d_nxt = pin_s[PIN_SCLK];
      ste_act = (pin_s[PIN_STE] == STE_ACTIVE);
      ste_ok = !(ctrl_r.four_pin_mode && !ctrl_r.enable_pin_mode_select) || ste_act;
      act = pin_s[PIN_SCLK] ^ ctrl_r.clock_polarity_sel;
      prev_act = sclk_d_r ^ ctrl_r.clock_polarity_sel;
      rx_in = ctrl_r.master_mode ? pin_s[PIN_SOMI] : pin_s[PIN_SIMO];
      if (wr_txb) begin
         txbuf_nxt = i_avs_writedata[7:0];
         txfull_nxt = 1'b1;
      end
      // slave counts edges only after the clock has been seen idle, so a stray level is no edge
      if (!act) begin
         armed_nxt = 1'b1; // R09
      end
      if (ctrl_r.soft_reset_bit) begin
         state_nxt = SSP_IDLE; // R07
         hcnt_nxt = '0;
         divcnt_nxt = '0;
         sr_nxt = BYTE_ZERO;
         rsr_nxt = BYTE_ZERO;
         txfull_nxt = 1'b0;
         dout_nxt = 1'b0;
         armed_nxt = 1'b0; // R09
         sclk_nxt = ctrl_r.clock_polarity_sel; // R03
      end else if (ctrl_r.master_mode) begin
         case (state_r)
            SSP_IDLE: begin
               sclk_nxt = ctrl_r.clock_polarity_sel; // R03
               hcnt_nxt = '0;
               if (txfull_r && ste_ok) begin // R02
                  load_v = 1'b1;
                  divcnt_nxt = '0;
                  state_nxt = SSP_XFER;
               end
            end
            SSP_XFER: begin
               if (!ste_ok) begin
                  // the character in flight is dropped; software must reload it
                  state_nxt = SSP_IDLE; // R02
                  hcnt_nxt = '0;
                  sclk_nxt = ctrl_r.clock_polarity_sel;
                  flag_set[FLG_ABT] = 1'b1;
               end else if (divcnt_r == div_r) begin
                  divcnt_nxt = '0;
                  edge_v = 1'b1;
                  lead_v = !hcnt_r[0];
                  sclk_nxt = !sclk_r;
               end else begin
                  divcnt_nxt = divcnt_r + 8'h01;
               end
            end
            default: state_nxt = SSP_IDLE;
         endcase
      end else begin
         if (ctrl_r.four_pin_mode && !ste_act) begin
            state_nxt = SSP_IDLE;
            hcnt_nxt = '0;
         end else begin
            case (state_r)
               SSP_IDLE: begin
                  load_v = 1'b1;
                  state_nxt = SSP_XFER;
               end
               SSP_XFER: begin
                  edge_v = armed_r && (act ^ prev_act); // R09
                  lead_v = act;
                  // a byte written while the shifter waits for its first edge goes out in this character
                  if (hcnt_r == '0 && !edge_v && txfull_r) begin
                     load_v = 1'b1; // R05
                  end
               end
               default: state_nxt = SSP_IDLE;
            endcase
         end
      end
      if (edge_v) begin
         hcnt_nxt = hcnt_r + 4'h1;
         if (lead_v == ctrl_r.clock_phase_sel) begin
            dout_nxt = sr_r[7];
            sr_nxt = {sr_r[6:0], 1'b0};
         end else begin
            rsr_nxt = {rsr_r[6:0], rx_in};
            rx_byte = {rsr_r[6:0], rx_in};
         end
         if (hcnt_r == HALF_LAST) begin
            rxbuf_nxt = rx_byte;
            flag_set[FLG_RX] = 1'b1; // R05
            if (!ctrl_r.master_mode || (txfull_r && ste_ok)) begin
               load_v = 1'b1;
            end else begin
               state_nxt = SSP_IDLE; // R06
            end
         end
      end
      if (load_v) begin
         if (txfull_r) begin
            byte_v = txbuf_r;
            txfull_nxt = wr_txb;
            flag_set[FLG_TX] = 1'b1; // R05
         end
         // phase 0 puts the first bit out before the first edge, phase 1 on it
         if (ctrl_r.clock_phase_sel) begin
            sr_nxt = byte_v; // R09
         end else begin
            dout_nxt = byte_v[7];
            sr_nxt = {byte_v[6:0], 1'b0};
         end
      end
      // set wins over both the write-one clear and the buffer-write clear
      flag_nxt = (flag_r & ~w1c & ~{{(NFLAG-1){1'b0}}, wr_txb}) | flag_set;
      if (ctrl_r.soft_reset_bit) begin
         flag_nxt = FLAG_RST; // R07
      end
      busy_nxt = (state_nxt == SSP_XFER) && (ctrl_r.master_mode || hcnt_nxt != '0); // R06
      irq_nxt = |(flag_nxt & mask_nxt);
      sclk_oe_nxt = ctrl_r.master_mode;
      simo_oe_nxt = ctrl_r.master_mode;
      somi_oe_nxt = !ctrl_r.master_mode && (!ctrl_r.four_pin_mode || ste_act);
      ste_oe_nxt = ctrl_r.master_mode && ctrl_r.four_pin_mode && ctrl_r.enable_pin_mode_select; // R01
      ste_o_nxt = (state_nxt == SSP_XFER) ? STE_ACTIVE : !STE_ACTIVE; // R01
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_r <= SSP_IDLE;
         hcnt_r <= '0;
         divcnt_r <= '0;
         sr_r <= BYTE_ZERO;
         rsr_r <= BYTE_ZERO;
         rxbuf_r <= BYTE_ZERO;
         txbuf_r <= BYTE_ZERO;
         txfull_r <= 1'b0;
         sclk_r <= 1'b0;
         dout_r <= 1'b0;
         sclk_d_r <= 1'b0;
         armed_r <= 1'b0;
         flag_r <= FLAG_RST;
         busy_r <= 1'b0;
         irq_r <= 1'b0;
         sclk_oe_r <= 1'b0;
         simo_oe_r <= 1'b0;
         somi_oe_r <= 1'b0;
         ste_oe_r <= 1'b0;
         ste_o_r <= !STE_ACTIVE;
      end else begin
         state_r <= state_nxt;
         hcnt_r <= hcnt_nxt;
         divcnt_r <= divcnt_nxt;
         sr_r <= sr_nxt;
         rsr_r <= rsr_nxt;
         rxbuf_r <= rxbuf_nxt;
         txbuf_r <= txbuf_nxt;
         txfull_r <= txfull_nxt;
         sclk_r <= sclk_nxt;
         dout_r <= dout_nxt;
         sclk_d_r <= sclk_d_nxt;
         armed_r <= armed_nxt;
         flag_r <= flag_nxt;
         busy_r <= busy_nxt;
         irq_r <= irq_nxt;
         sclk_oe_r <= sclk_oe_nxt;
         simo_oe_r <= simo_oe_nxt;
         somi_oe_r <= somi_oe_nxt;
         ste_oe_r <= ste_oe_nxt;
         ste_o_r <= ste_o_nxt;
      end
   end

   assign o_avs_readdata = rdata_r;
   assign o_avs_waitrequest = wait_r;
   assign o_sclk = sclk_r;
   assign o_sclk_oe = sclk_oe_r;
   assign o_simo = dout_r;
   assign o_simo_oe = simo_oe_r;
   assign o_somi = dout_r;
   assign o_somi_oe = somi_oe_r;
   assign o_slave_enable_pin = ste_o_r;
   assign o_slave_enable_pin_oe = ste_oe_r;
   assign o_irq = irq_r;
   assign o_transfer_active_flag = busy_r;
   assign o_clk_req = busy_r; // R06
endmodule // ssp_core
`default_nettype wire

// ===== rtl/ssp_pkg.sv
// constants, field layouts and types shared by the serial port core
package ssp_pkg;
   // register bus
   localparam int AW = 5;
   localparam int DW = 32;
   localparam logic [AW-1:0] OFS_CTRL = 5'h00;
   localparam logic [AW-1:0] OFS_DIV = 5'h04;
   localparam logic [AW-1:0] OFS_STAT = 5'h08;
   localparam logic [AW-1:0] OFS_FLAG = 5'h0C;
   localparam logic [AW-1:0] OFS_MASK = 5'h10;
   localparam logic [AW-1:0] OFS_TXB = 5'h14;
   localparam logic [AW-1:0] OFS_RXB = 5'h18;

   // port control word, bit 0 is soft_reset_bit
   typedef struct packed {
      logic enable_pin_mode_select;
      logic four_pin_mode;
      logic clock_polarity_sel;
      logic clock_phase_sel;
      logic master_mode;
      logic soft_reset_bit;
   } ssp_ctrl_t;
   localparam ssp_ctrl_t CTRL_RST = 6'h01;

   // event flags and mask share this layout
   localparam int NFLAG = 3;
   localparam int FLG_TX = 0;
   localparam int FLG_RX = 1;
   localparam int FLG_ABT = 2;
   localparam logic [NFLAG-1:0] FLAG_RST = 3'h0;
   localparam logic [NFLAG-1:0] MASK_RST = 3'h0;

   // status bits
   localparam int ST_BUSY = 0;
   localparam int ST_TXFULL = 1;

   // half bit period is (divider + 1) system cycles
   localparam logic [7:0] DIV_RST = 8'h07;
   localparam logic [3:0] HALF_LAST = 4'hF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // slave enable pin is active low
   localparam logic STE_ACTIVE = 1'b0;

   // synchronised pin vector
   localparam int NPIN = 4;
   localparam int PIN_SCLK = 0;
   localparam int PIN_SIMO = 1;
   localparam int PIN_SOMI = 2;
   localparam int PIN_STE = 3;

   typedef enum logic {SSP_IDLE, SSP_XFER} ssp_state_t;
endpackage

// ===== rtl/ssp_sync.sv
// two flip-flop synchroniser for the serial port pins
`timescale 1ns/1ps
`default_nettype none
module ssp_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // asynchronous in, synchronous out
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = i_d;
      q_nxt = meta_r;
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         meta_r <= '0;
         o_q <= '0;
      end else begin
         meta_r <= meta_nxt;
         o_q <= q_nxt;
      end
   end
endmodule // ssp_sync
`default_nettype wire

// ===== verif/ssp_monitor.sv
// port checker for the serial port core
`timescale 1ns/1ps
`default_nettype none
module ssp_monitor (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // watched ports
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic o_avs_waitrequest,
   input wire logic o_sclk,
   input wire logic o_sclk_oe,
   input wire logic o_simo_oe,
   input wire logic i_slave_enable_pin,
   input wire logic o_slave_enable_pin,
   input wire logic o_slave_enable_pin_oe,
   input wire logic o_irq,
   input wire logic o_transfer_active_flag,
   input wire logic o_clk_req
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   logic req;
   logic bsy;
   assign req = i_avs_read | i_avs_write;
   assign bsy = o_transfer_active_flag;
   a_wait_one: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("no answer one cycle after request");
   a_wait_short: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   a_no_spurious: assert property (!req && o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("answer without request");
   a_busy_req: assert property (o_clk_req == bsy)
      else $error("clock request differs from busy");
   // divider left at reset value, so a half bit is 8 cycles
   a_half_bit: assert property ($changed(o_sclk) && bsy && o_sclk_oe |=>
      ($stable(o_sclk) || !bsy) [*7] ##1 ($changed(o_sclk) || !bsy))
      else $error("serial clock half period wrong");
   a_ste_low: assert property (o_slave_enable_pin_oe && bsy && $past(bsy) |-> !o_slave_enable_pin)
      else $error("enable output not active in transfer");
   a_ste_idle: assert property (o_slave_enable_pin_oe && !bsy && !$past(bsy) |-> o_slave_enable_pin)
      else $error("enable output active while idle");
   a_ste_master: assert property (o_slave_enable_pin_oe |-> o_sclk_oe)
      else $error("enable output outside master mode");
   a_pin_dir: assert property (o_simo_oe == o_sclk_oe)
      else $error("data and clock direction differ");
   // inactive select in conflict mode must stop the shifter within sync latency
   a_abort_stop: assert property (o_sclk_oe && !o_slave_enable_pin_oe && i_slave_enable_pin && bsy
      |-> ##[1:6] !bsy)
      else $error("transfer not aborted");
   c_xfer: cover property (bsy && o_sclk_oe);
   c_slave: cover property (bsy && !o_sclk_oe);
   c_irq: cover property ($rose(o_irq));
endmodule // ssp_monitor

bind ssp_core ssp_monitor i_mon (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_read(i_avs_read),
   .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .o_sclk(o_sclk),
   .o_sclk_oe(o_sclk_oe), .o_simo_oe(o_simo_oe), .i_slave_enable_pin(i_slave_enable_pin),
   .o_slave_enable_pin(o_slave_enable_pin), .o_slave_enable_pin_oe(o_slave_enable_pin_oe),
   .o_irq(o_irq), .o_transfer_active_flag(o_transfer_active_flag), .o_clk_req(o_clk_req));
`default_nettype wire

// ===== verif/ssp_far_model.sv
// behavioural far-side slave, phase 0, for master runs
`timescale 1ns/1ps
`default_nettype none
module ssp_far_model (
   // pins
   input wire logic i_sclk,
   input wire logic i_simo,
   input wire logic i_sel_n,
   output logic o_somi,
   // set-up and result
   input wire logic i_cpol,
   input wire logic [7:0] i_tx,
   output logic [7:0] o_rx
);
   int b = 0;
   logic last = 1'b0;
   // deselected output shows the inverse of the last bit, not a stale copy
   always_comb o_somi = i_sel_n ? ~last : i_tx[7-b];
   // deselect realigns the bit count, as after an abort
   always @(posedge i_sel_n) b = 0;
   always @(i_sclk) begin
      if (!i_sel_n && (i_sclk !== i_cpol)) begin
         o_rx = {o_rx[6:0], i_simo};
      end else if (!i_sel_n) begin
         last = i_tx[7-b];
         b = (b + 1) % 8;
      end
   end
endmodule // ssp_far_model
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the serial port core
`timescale 1ns/1ps
`default_nettype none
module tb;
   import ssp_pkg::*;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [AW-1:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [DW-1:0] wd = 32'h0;
   logic [DW-1:0] rdat;
   logic wt, sck, sck_oe, mosi, mosi_oe, miso, miso_oe, ste, ste_oe, irq, busy, creq, m_miso;
   logic t_sck = 1'b0;
   logic t_mosi = 1'b0;
   logic t_ste = 1'b0;
   logic m_sel = 1'b1;
   logic m_cpol = 1'b0;
   logic [7:0] m_tx = 8'h00;
   logic [7:0] m_rx, md, got;
   logic [7:0] mds [3] = '{8'h02, 8'h0A, 8'h32};
   logic [7:0] mo [3] = '{8'hA5, 8'h3C, 8'hC1};
   logic [7:0] mi [3] = '{8'h5A, 8'h96, 8'h7E};
   int err_count = 0;
   int num_checks = 0;
   // each pin level comes from whichever party enables it
   wire logic w_sck = sck_oe ? sck : t_sck;
   wire logic w_mosi = mosi_oe ? mosi : t_mosi;
   wire logic w_miso = miso_oe ? miso : m_miso;
   wire logic w_ste = ste_oe ? ste : t_ste;
   initial begin
      forever #5 i_clk = ~i_clk;
   end
   ssp_core i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wt), .i_sclk(w_sck), .o_sclk(sck), .o_sclk_oe(sck_oe), .i_simo(w_mosi),
      .o_simo(mosi), .o_simo_oe(mosi_oe), .i_somi(w_miso), .o_somi(miso), .o_somi_oe(miso_oe),
      .i_slave_enable_pin(w_ste), .o_slave_enable_pin(ste), .o_slave_enable_pin_oe(ste_oe),
      .o_irq(irq), .o_transfer_active_flag(busy), .o_clk_req(creq));
   ssp_far_model i_far (.i_sclk(w_sck), .i_simo(w_mosi), .i_sel_n(m_sel), .o_somi(m_miso),
      .i_cpol(m_cpol), .i_tx(m_tx), .o_rx(m_rx));
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [AW-1:0] a, input logic [7:0] d, output logic [31:0] q);
      int n;
      n = 0;
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= {24'h0, d};
      @(posedge i_clk);
      while (wt !== 1'b0) begin
         n++;
         if (n > 50) begin
            err_count++;
            test_done();
         end
         @(posedge i_clk);
      end
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic wrr(input logic [AW-1:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [AW-1:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      @(posedge i_clk);
      while (irq !== 1'b1) begin
         n++;
         if (n > 2000) begin
            err_count++;
            test_done();
         end
         @(posedge i_clk);
      end
   endtask
   // link clock of 160 ns, offset so its edges never meet the system clock edge
   task automatic xfer(input logic [7:0] o, output logic [7:0] i);
      #3;
      for (int k = 7; k >= 0; k--) begin
         #80 t_sck = 1'b1;
         t_mosi = o[k];
         #80 i[k] = w_miso;
         t_sck = 1'b0;
      end
      #80 t_mosi = ~t_mosi;
      @(posedge i_clk);
   endtask
   initial begin
      repeat (8) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      @(posedge i_clk);
      rdc(OFS_CTRL, 32'h01);
      rdc(OFS_DIV, 32'h07);
      rdc(OFS_MASK, 32'h0);
      rdc(OFS_FLAG, 32'h0);
      wrr(5'h1C, 8'hFF);
      rdc(5'h1C, 32'h0);
      for (int k = 0; k < 3; k++) begin
         md = mds[k];
         wrr(OFS_CTRL, md | 8'h01);
         wrr(OFS_CTRL, md);
         m_cpol <= md[3];
         m_tx <= mi[k];
         m_sel <= 1'b1;
         repeat (2) @(posedge i_clk);
         chk(sck, md[3]);
         m_sel <= 1'b0;
         wrr(OFS_MASK, 8'h02);
         wrr(OFS_TXB, mo[k]);
         wait_irq();
         chk(m_rx, mo[k]);
         rdc(OFS_RXB, mi[k]);
         rdc(OFS_FLAG, 32'h3);
         rdc(OFS_STAT, 32'h0);
         chk(creq, 1'b0);
         wrr(OFS_MASK, 8'h00);
         rdc(OFS_FLAG, 32'h3);
         chk(irq, 1'b0);
         wrr(OFS_FLAG, 8'h07);
         rdc(OFS_FLAG, 32'h0);
      end
      wrr(OFS_CTRL, 8'h13);
      wrr(OFS_CTRL, 8'h12);
      wrr(OFS_TXB, 8'hF0);
      repeat (40) @(posedge i_clk);
      chk(busy, 1'b1);
      t_ste <= 1'b1;
      m_sel <= 1'b1;
      repeat (10) @(posedge i_clk);
      chk(busy, 1'b0);
      rdc(OFS_FLAG, 32'h5);
      t_ste <= 1'b0;
      m_sel <= 1'b0;
      repeat (30) @(posedge i_clk);
      chk(busy, 1'b0);
      wrr(OFS_FLAG, 8'h07);
      wrr(OFS_MASK, 8'h02);
      wrr(OFS_TXB, mo[0]);
      wait_irq();
      chk(m_rx, mo[0]);
      wrr(OFS_CTRL, 8'h05);
      wrr(OFS_CTRL, 8'h04);
      wrr(OFS_FLAG, 8'h07);
      for (int k = 0; k < 3; k++) begin
         wrr(OFS_TXB, mo[k]);
         xfer(mi[k], got);
         chk(got, mo[k]);
         wait_irq();
         rdc(OFS_RXB, mi[k]);
         rdc(OFS_FLAG, 32'h3);
         if (k == 1) begin
            wrr(OFS_TXB, 8'h11);
            wrr(OFS_CTRL, 8'h05);
            rdc(OFS_FLAG, 32'h0);
            rdc(OFS_STAT, 32'h0);
            wrr(OFS_CTRL, 8'h04);
         end else begin
            wrr(OFS_FLAG, 8'h07);
         end
      end
      test_done();
   end
endmodule // tb
`default_nettype wire
